/* File: src/scs_pkg.sv */
// Package for the system clock source selector: register layout,
// mode encodings, reset values and timing counts.
// Assumes a single 20 MHz system clock domain.
package scs_pkg;

  // Control register offset on the plain register port
  localparam logic [1:0] OFS_OSC_CTRL = 2'h0;
  // Fail flag register offset (software clears by writing 1)
  localparam logic [1:0] OFS_FAIL_FLAG = 2'h1;

  // Field positions in the control register
  localparam int FREQ_MSB = 6;
  localparam int FREQ_LSB = 4;
  localparam int EXT_RUN_BIT = 3;
  localparam int HF_STABLE_BIT = 2;
  localparam int LF_STABLE_BIT = 1;
  localparam int SEL_BIT = 0;
  // Fail flag position in its register
  localparam int FAIL_FLAG_BIT = 2;

  // Reset values
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic SEL_RESET = 1'b0;

  // Internal frequency codes
  localparam logic [2:0] FREQ_LF_CODE = 3'h0;
  localparam logic [2:0] FREQ_MAX_CODE = 3'h7;

  // Crystal start-up count in oscillator input cycles
  localparam int XTAL_STARTUP_CYCLES = 1024;
  // Oscillator warm-up times and derived counts at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int HF_WARM_NS = 1000;
  localparam int HF_WARM_CYC = (HF_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LF_WARM_NS = 2000;
  localparam int LF_WARM_CYC = (LF_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // External clock missing this long is a failure (in ns, then in system cycles)
  localparam int FAIL_TIMEOUT_NS = 3200;
  localparam int FAIL_TIMEOUT_CYC = FAIL_TIMEOUT_NS / CLK_PERIOD_NS;

  // Clock source modes of the nonvolatile configuration field
  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE = 3'b000,
    MEDIUM_GAIN_CRYSTAL_MODE = 3'b001,
    HIGH_GAIN_CRYSTAL_MODE = 3'b010,
    EXTERNAL_CLOCK_MODE = 3'b011,
    INTERNAL_OSC_IO_MODE = 3'b100,
    INTERNAL_OSC_CLOCK_OUTPUT_PIN_MODE = 3'b101,
    RESISTOR_CAPACITOR_IO_MODE = 3'b110,
    RESISTOR_CAPACITOR_MODE = 3'b111
  } scs_mode_t;

  // Nonvolatile configuration carried as one group
  typedef struct packed {
    scs_mode_t mode;
    logic two_speed_en;
    logic fail_monitor_en;
  } scs_cfg_t;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scs_bus_req_t;

  // Oscillator pin control: oe low means the block drives the pin
  typedef struct packed {
    logic in_pin_is_io;
    logic out_pin_oe_n;
    logic out_pin_val;
  } scs_pins_t;

endpackage

/* File: src/scs_clock_selector.sv */
// System clock source selector: mode decode, control register, crystal
// start-up counter, fail monitor and glitch-free source switch.
// Assumes all inputs synchronous to i_clk_sys; oscillator input edges
// arrive as a sampled level on i_osc_in.
// Functional notes
// - Exactly one of eight source modes from 3-bit configuration field.
// - External clock mode takes logic clock on input pin, output pin is I/O.
// - RC mode drives clock/4 on output pin; RC I/O variant frees it.
// - Internal mode drives clock/4 out, input pin I/O; I/O variant frees both.
// - Bits 6-4 select 8 MHz down to 125 kHz; code 000 picks 31 kHz.
// - Frequency field resets to 110, 4 MHz.
// - Bit 3 reads 1 when running from the external clock.
// - Bit 3 resets 0 with two-speed crystal or fail monitor, else 1; both internal oscillator modes give 0 here.
// - Bit 2 reads 1 when the high-frequency oscillator is stable.
// - Bit 1 reads 1 when the low-frequency oscillator is stable.
// - Bit 0 resets 0; 1 selects internal oscillator as system clock.
// - Bit 7 is unimplemented and reads zero.
// - Crystal modes count 1024 input cycles after reset, timer, wake.
// - Execution is held while the start-up count runs.
// - External clock mode skips the start-up count.
// - Stopped external clock halts device, state kept, resumes later.
// - Fail monitor switches to internal oscillator when external clock lost.
// - Two internal oscillators: 8 MHz calibrated and 31 kHz.
// - Oscillator failure sets a fail flag that software clears.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

module scs_clock_selector #(
  parameter int XTAL_COUNT = scs_pkg::XTAL_STARTUP_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // Configuration and power events
  input wire scs_pkg::scs_cfg_t i_cfg,
  input wire logic i_power_up_timer_done,
  input wire logic i_wake,
  // Oscillator input sample and internal oscillator ready flags
  input wire logic i_osc_in,
  input wire logic i_hf_osc_ready,
  input wire logic i_lf_osc_ready,
  // Register port
  input wire scs_pkg::scs_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // Pins and clock path
  output scs_pkg::scs_pins_t o_pins,
  output logic o_use_internal,
  output logic [2:0] o_internal_freq_select,
  output logic o_exec_hold,
  output logic o_oscillator_fail_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Mode decode helpers

  // Crystal family modes need the start-up count
  function automatic logic is_crystal(input scs_pkg::scs_mode_t m);
    return (m == scs_pkg::LOW_POWER_CRYSTAL_MODE) ||
           (m == scs_pkg::MEDIUM_GAIN_CRYSTAL_MODE) ||
           (m == scs_pkg::HIGH_GAIN_CRYSTAL_MODE);
  endfunction

  // Internal oscillator modes have no external source
  function automatic logic is_internal(input scs_pkg::scs_mode_t m);
    return (m == scs_pkg::INTERNAL_OSC_IO_MODE) ||
           (m == scs_pkg::INTERNAL_OSC_CLOCK_OUTPUT_PIN_MODE);
  endfunction

  scs_pkg::scs_mode_t mode;
  logic mode_xtal;
  logic mode_int;
  assign mode = i_cfg.mode;
  assign mode_xtal = is_crystal(mode);
  assign mode_int = is_internal(mode);

  ////////////////////////////////////////////////////////////////////////
  // Control register writable fields

  logic [2:0] freq_r;
  logic sel_r;
  logic wr_ctrl;
  logic wr_flag;
  assign wr_ctrl = i_ce && i_bus.wr && (i_bus.addr == scs_pkg::OFS_OSC_CTRL);
  assign wr_flag = i_ce && i_bus.wr && (i_bus.addr == scs_pkg::OFS_FAIL_FLAG);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      freq_r <= scs_pkg::FREQ_RESET;
    end else if (wr_ctrl) begin
      freq_r <= i_bus.wdata[scs_pkg::FREQ_MSB:scs_pkg::FREQ_LSB];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sel_r <= scs_pkg::SEL_RESET;
    end else if (wr_ctrl) begin
      sel_r <= i_bus.wdata[scs_pkg::SEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal oscillator warm-up tracking

  // Stable flags rise only after the warm-up time has passed
  logic [7:0] hf_cnt_r;
  logic [7:0] lf_cnt_r;
  logic hf_stable_r;
  logic lf_stable_r;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hf_cnt_r <= 8'h00;
      hf_stable_r <= 1'b0;
    end else if (i_ce) begin
      if (!i_hf_osc_ready) begin
        hf_cnt_r <= 8'h00;
        hf_stable_r <= 1'b0;
      end else if (hf_cnt_r == 8'(scs_pkg::HF_WARM_CYC - 1)) begin
        hf_stable_r <= 1'b1;
      end else begin
        hf_cnt_r <= hf_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lf_cnt_r <= 8'h00;
      lf_stable_r <= 1'b0;
    end else if (i_ce) begin
      if (!i_lf_osc_ready) begin
        lf_cnt_r <= 8'h00;
        lf_stable_r <= 1'b0;
      end else if (lf_cnt_r == 8'(scs_pkg::LF_WARM_CYC - 1)) begin
        lf_stable_r <= 1'b1;
      end else begin
        lf_cnt_r <= lf_cnt_r + 8'h01;
      end
    end
  end

  // The stable flag of whichever internal source the field selects
  logic int_stable;
  assign int_stable = (freq_r == scs_pkg::FREQ_LF_CODE) ? lf_stable_r : hf_stable_r;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator input edge detection

  // Inputs are synchronous, so one register is enough for edge finding
  logic osc_d_r;
  logic osc_rise;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      osc_d_r <= 1'b0;
    end else if (i_ce) begin
      osc_d_r <= i_osc_in;
    end
  end
  assign osc_rise = i_osc_in && !osc_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Crystal start-up counter

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_READY = 2'b10
  } scs_ost_t;

  scs_ost_t ost_r;
  logic [10:0] ost_cnt_r;
  logic ost_start;
  logic boot_r;
  // Start after reset release (boot_r), power-up timer or wake
  assign ost_start = boot_r || i_power_up_timer_done || i_wake;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      boot_r <= 1'b1;
    end else if (i_ce) begin
      boot_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ost_r <= ST_IDLE;
      ost_cnt_r <= 11'h000;
    end else if (i_ce) begin
      unique case (ost_r)
        ST_IDLE, ST_READY: begin
          if (ost_start && mode_xtal) begin
            ost_r <= ST_COUNT;
            ost_cnt_r <= 11'h000;
          end else if (ost_start) begin
            ost_r <= ST_READY;
          end
        end
        ST_COUNT: begin
          if (osc_rise) begin
            if (ost_cnt_r == 11'(XTAL_COUNT - 1)) begin
              ost_r <= ST_READY;
            end else begin
              ost_cnt_r <= ost_cnt_r + 11'h001;
            end
          end
        end
        default: ost_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fail monitor

  // Loss of edges on the input for the timeout marks a failed source
  logic [7:0] fail_cnt_r;
  logic ext_failed_r;
  logic monitored;
  assign monitored = i_cfg.fail_monitor_en && !mode_int && (ost_r == ST_READY);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fail_cnt_r <= 8'h00;
      ext_failed_r <= 1'b0;
    end else if (i_ce) begin
      if (!monitored || osc_rise) begin
        fail_cnt_r <= 8'h00;
        ext_failed_r <= 1'b0;
      end else if (fail_cnt_r == 8'(scs_pkg::FAIL_TIMEOUT_CYC - 1)) begin
        ext_failed_r <= 1'b1;
      end else begin
        fail_cnt_r <= fail_cnt_r + 8'h01;
      end
    end
  end

  // sticky fail flag, set wins over clear
  logic fail_rise;
  logic ext_failed_d_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ext_failed_d_r <= 1'b0;
      o_oscillator_fail_flag <= 1'b0;
    end else if (i_ce) begin
      ext_failed_d_r <= ext_failed_r;
      if (fail_rise) begin
        o_oscillator_fail_flag <= 1'b1;
      end else if (wr_flag && i_bus.wdata[scs_pkg::FAIL_FLAG_BIT]) begin
        o_oscillator_fail_flag <= 1'b0;
      end
    end
  end
  assign fail_rise = ext_failed_r && !ext_failed_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Source selection

  // Wanted source: internal when selected, in internal mode or on failure
  logic want_int;
  logic ext_ready;
  assign want_int = sel_r || mode_int || ext_failed_r;
  assign ext_ready = (ost_r == ST_READY) && !ext_failed_r;

  // switch only when the target is stable; on failure go internal at once
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      // status reset: external, whatever the two-speed or monitor setting
      o_use_internal <= 1'b0;
    end else if (i_ce) begin
      if (ext_failed_r) begin
        o_use_internal <= 1'b1;
      end else if (want_int && int_stable) begin
        o_use_internal <= 1'b1;
      end else if (!want_int && ext_ready) begin
        o_use_internal <= 1'b0;
      end
    end
  end

  // Reset-time status bit: captured after release, since config is a port
  logic ext_run_r;
  logic ext_run_reset;
  assign ext_run_reset = !((i_cfg.two_speed_en && mode_xtal) || i_cfg.fail_monitor_en);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ext_run_r <= 1'b0;
    end else if (i_ce) begin
      if (boot_r) begin
        ext_run_r <= ext_run_reset && !mode_int;
      end else begin
        ext_run_r <= !o_use_internal && !mode_int && (ext_ready || ext_run_r); // Kept in count
      end
    end
  end

  // Internal frequency handed to the clock tree
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_internal_freq_select <= scs_pkg::FREQ_RESET;
    end else if (i_ce && int_stable) begin
      o_internal_freq_select <= freq_r;
    end
  end

  // enable low freezes the hold with all other state
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_exec_hold <= 1'b1;
    end else if (i_ce) begin
      o_exec_hold <= (ost_r != ST_READY);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin functions and clock divided by four

  logic [1:0] div_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 2'h0;
    end else if (i_ce) begin
      div_r <= div_r + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pins <= '{in_pin_is_io: 1'b0, out_pin_oe_n: 1'b1, out_pin_val: 1'b0};
    end else if (i_ce) begin
      o_pins.out_pin_val <= div_r[1];
      unique case (mode)
        scs_pkg::EXTERNAL_CLOCK_MODE,
        scs_pkg::RESISTOR_CAPACITOR_IO_MODE: begin
          o_pins.in_pin_is_io <= 1'b0;
          o_pins.out_pin_oe_n <= 1'b1;
        end
        scs_pkg::RESISTOR_CAPACITOR_MODE: begin
          o_pins.in_pin_is_io <= 1'b0;
          o_pins.out_pin_oe_n <= 1'b0;
        end
        scs_pkg::INTERNAL_OSC_CLOCK_OUTPUT_PIN_MODE: begin
          o_pins.in_pin_is_io <= 1'b1;
          o_pins.out_pin_oe_n <= 1'b0;
        end
        scs_pkg::INTERNAL_OSC_IO_MODE: begin
          o_pins.in_pin_is_io <= 1'b1;
          o_pins.out_pin_oe_n <= 1'b1;
        end
        // Crystal modes use both pins for the resonator
        scs_pkg::LOW_POWER_CRYSTAL_MODE, scs_pkg::MEDIUM_GAIN_CRYSTAL_MODE,
        scs_pkg::HIGH_GAIN_CRYSTAL_MODE: begin
          o_pins.in_pin_is_io <= 1'b0;
          o_pins.out_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe

  logic [7:0] ctrl_view;
  assign ctrl_view = {1'b0, freq_r, ext_run_r, hf_stable_r, lf_stable_r, sel_r};

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_bus.rd && i_bus.addr == scs_pkg::OFS_OSC_CTRL) begin
        o_rdata <= ctrl_view;
      end else if (i_bus.rd && i_bus.addr == scs_pkg::OFS_FAIL_FLAG) begin
        o_rdata <= 8'({o_oscillator_fail_flag, 2'b00});
      end else begin
        // Unmapped reads and idle cycles return zero
        o_rdata <= 8'h00;
      end
    end
  end

endmodule // scs_clock_selector

/* File: test/scs_osc_model.sv */
// Behavioural model of the outside oscillator feeding the input pin.
// Assumes the selector samples the pin level on the system clock.
`timescale 1ns/100ps

module scs_osc_model #(
  parameter int HALF = 3
) (
  // Clock and run control
  input wire logic i_clk_sys,
  input wire logic i_run,
  // Oscillator pin level
  output logic o_osc
);
  int cnt;

  initial begin
    cnt = 0;
    o_osc = 1'b0;
  end

  // clock may stop
  // A stopped source parks low, so a missing clock never looks like an edge
  always @(posedge i_clk_sys) begin
    if (!i_run) begin
      cnt <= 0;
      o_osc <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      o_osc <= ~o_osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // scs_osc_model

/* File: test/scs_clock_selector_asserts.sv */
// Checker for the clock source selector, bound to its ports.
// Assumes inputs change just after rising edges of i_clk_sys.
`timescale 1ns/100ps

module scs_clock_selector_asserts #(
  parameter int XTAL_COUNT = scs_pkg::XTAL_STARTUP_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // Configuration and events
  input wire scs_pkg::scs_cfg_t i_cfg,
  input wire logic i_power_up_timer_done,
  input wire logic i_wake,
  input wire logic i_osc_in,
  input wire logic i_hf_osc_ready,
  input wire logic i_lf_osc_ready,
  // Register port and outputs
  input wire scs_pkg::scs_bus_req_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire scs_pkg::scs_pins_t o_pins,
  input wire logic o_use_internal,
  input wire logic [2:0] o_internal_freq_select,
  input wire logic o_exec_hold,
  input wire logic o_oscillator_fail_flag
);
  logic osc_q;
  int unsigned edges;
  int unsigned gap;
  int unsigned age;
  logic xtal;
  logic ext;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // Crystal modes without two-speed start are the ones that must hold
  assign xtal = (i_cfg.mode <= scs_pkg::HIGH_GAIN_CRYSTAL_MODE) && !i_cfg.two_speed_en;
  assign ext = (i_cfg.mode[2:1] != 2'b10);

  // Input edge count and gap; frozen with the enable like the design
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      osc_q <= 1'b0;
      edges <= 0;
      gap <= 0;
    end else if (i_ce) begin
      osc_q <= i_osc_in;
      if (i_wake || i_power_up_timer_done) begin
        edges <= 0;
      end else if (age != 0 && i_osc_in && !osc_q && edges <= XTAL_COUNT) begin
        edges <= edges + 1;
      end
      gap <= (i_osc_in && !osc_q) ? 0 : ((gap < 1000) ? gap + 1 : gap);
    end
  end

  // Cycles since reset, saturating
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      age <= 0;
    end else if (age < 15) begin
      age <= age + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  bit7_zero_a: assert property ($past(i_bus.rd && i_ce) |-> !o_rdata[7])
    else $error("bit 7 read as one");
  hf_status_a: assert property ($past(i_bus.rd && i_ce) && !$past(i_hf_osc_ready)
    && $past(i_bus.addr) == scs_pkg::OFS_OSC_CTRL
    && !$past(i_hf_osc_ready, 2) |-> !o_rdata[2]) else $error("hf stable without osc");
  lf_status_a: assert property ($past(i_bus.rd && i_ce) && !$past(i_lf_osc_ready)
    && $past(i_bus.addr) == scs_pkg::OFS_OSC_CTRL
    && !$past(i_lf_osc_ready, 2) |-> !o_rdata[1]) else $error("lf stable without osc");
  xtal_early_a: assert property (xtal && $fell(o_exec_hold) |-> edges >= XTAL_COUNT)
    else $error("hold released before count");
  xtal_done_a: assert property (xtal && edges > XTAL_COUNT |-> !o_exec_hold)
    else $error("hold kept after count");
  ec_run_a: assert property (i_cfg.mode == scs_pkg::EXTERNAL_CLOCK_MODE && i_ce
    && $fell(i_rst) |-> ##[1:3] !o_exec_hold) else $error("external mode delayed");
  ec_pins_a: assert property (i_cfg.mode == scs_pkg::EXTERNAL_CLOCK_MODE
    |-> o_pins.out_pin_oe_n && !o_pins.in_pin_is_io) else $error("external mode pins");
  io_pins_a: assert property (age > 2 && i_cfg.mode == scs_pkg::INTERNAL_OSC_IO_MODE
    |-> o_pins.out_pin_oe_n && o_pins.in_pin_is_io) else $error("internal io pins");
  clock_output_pin_div_a: assert property (age > 2 && i_cfg.mode[0] && i_cfg.mode[2] && $past(i_ce)
    && $past(i_ce, 2) && $past(i_ce, 3)
    |-> !o_pins.out_pin_oe_n && o_pins.out_pin_val != $past(o_pins.out_pin_val, 2))
    else $error("clock output not divided by four");
  fail_switch_a: assert property (i_cfg.fail_monitor_en && ext
    && gap >= scs_pkg::FAIL_TIMEOUT_CYC + 4 |-> o_use_internal) else $error("no fallback");
  fail_flag_a: assert property ($rose(o_oscillator_fail_flag) |-> ##[0:1] o_use_internal)
    else $error("fail flag without fallback");
  freeze_state_a: assert property (!$past(i_ce) |-> $stable(o_use_internal)
    && $stable(o_exec_hold) && $stable(o_internal_freq_select)) else $error("state moved");
endmodule // scs_clock_selector_asserts

bind scs_clock_selector scs_clock_selector_asserts #(.XTAL_COUNT(XTAL_COUNT)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_cfg(i_cfg),
  .i_power_up_timer_done(i_power_up_timer_done), .i_wake(i_wake), .i_osc_in(i_osc_in),
  .i_hf_osc_ready(i_hf_osc_ready), .i_lf_osc_ready(i_lf_osc_ready), .i_bus(i_bus),
  .o_rdata(o_rdata), .o_pins(o_pins), .o_use_internal(o_use_internal),
  .o_internal_freq_select(o_internal_freq_select), .o_exec_hold(o_exec_hold),
  .o_oscillator_fail_flag(o_oscillator_fail_flag));

/* File: test/tb.sv */
// Self-checking bench for the clock source selector.
// Assumes the oscillator model on the input pin and a short start-up count.
`timescale 1ns/100ps

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  scs_pkg::scs_cfg_t cfg = '0;
  logic power_up_timer = 1'b0;
  logic wake = 1'b0;
  logic run = 1'b1;
  logic hf_rdy = 1'b0;
  logic lf_rdy = 1'b0;
  scs_pkg::scs_bus_req_t bus = '0;
  logic osc;
  logic [7:0] rdata;
  scs_pkg::scs_pins_t pins;
  logic use_int;
  logic [2:0] fsel;
  logic hold;
  logic fflag;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] rv;

  // 20 MHz system clock
  always #25 clk = ~clk;

  scs_osc_model #(.HALF(3)) u_osc (.i_clk_sys(clk), .i_run(run), .o_osc(osc));

  // Short count keeps the run brief
  scs_clock_selector #(.XTAL_COUNT(8)) DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_cfg(cfg), .i_power_up_timer_done(power_up_timer),
    .i_wake(wake), .i_osc_in(osc), .i_hf_osc_ready(hf_rdy), .i_lf_osc_ready(lf_rdy),
    .i_bus(bus), .o_rdata(rdata), .o_pins(pins), .o_use_internal(use_int),
    .o_internal_freq_select(fsel), .o_exec_hold(hold), .o_oscillator_fail_flag(fflag));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input scs_pkg::scs_mode_t m, input logic ts, input logic fm);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= '{mode: m, two_speed_en: ts, fail_monitor_en: fm};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  // One-cycle strobes; read data stand in the cycle after the strobe
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Start-up count after reset, timer expiry and wake, then two-speed reset
  task automatic t_xtal();
    do_reset(scs_pkg::MEDIUM_GAIN_CRYSTAL_MODE, 1'b0, 1'b0);
    wait_clk(6);
    chk("hold counting", 8'h01, {7'h0, hold});
    bus_rd(scs_pkg::OFS_OSC_CTRL, rv);
    chk("ctrl reset", 8'h68, rv & 8'hf9);
    for (int i = 0; i < 2; i++) begin
      wait_clk(60);
      chk("hold done", 8'h00, {7'h0, hold});
      @(posedge clk);
      if (i == 0) power_up_timer <= 1'b1;
      else wake <= 1'b1;
      @(posedge clk);
      power_up_timer <= 1'b0;
      wake <= 1'b0;
      wait_clk(8);
      chk("hold again", 8'h01, {7'h0, hold});
    end
    do_reset(scs_pkg::MEDIUM_GAIN_CRYSTAL_MODE, 1'b1, 1'b0);
    bus_rd(scs_pkg::OFS_OSC_CTRL, rv);
    chk("two speed run bit", 8'h00, rv & 8'h08);
  endtask

  // Clock stopped mid-count freezes everything, then resumes
  task automatic t_freeze();
    do_reset(scs_pkg::HIGH_GAIN_CRYSTAL_MODE, 1'b0, 1'b0);
    wait_clk(10);
    @(posedge clk);
    ce <= 1'b0;
    wait_clk(100);
    chk("frozen hold", 8'h01, {7'h0, hold});
    @(posedge clk);
    ce <= 1'b1;
    wait_clk(60);
    chk("resumed hold", 8'h00, {7'h0, hold});
  endtask

  // Select waits for a stable source; every frequency code; bit 7 stays zero
  task automatic t_freq();
    logic [2:0] c;
    bus_wr(scs_pkg::OFS_OSC_CTRL, 8'h61);
    wait_clk(40);
    chk("switch unstable", 8'h00, {7'h0, use_int});
    @(posedge clk);
    hf_rdy <= 1'b1;
    lf_rdy <= 1'b1;
    wait_clk(60);
    chk("switch stable", 8'h01, {7'h0, use_int});
    bus_rd(scs_pkg::OFS_OSC_CTRL, rv);
    chk("stable bits", 8'h06, rv & 8'h06);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      bus_wr(scs_pkg::OFS_OSC_CTRL, {1'b1, c, 4'hf});
      bus_rd(scs_pkg::OFS_OSC_CTRL, rv);
      chk("freq field", {1'b0, c, 4'h1}, rv & 8'hf1);
      wait_clk(40);
      chk("freq in use", {5'h0, c}, {5'h0, fsel});
    end
    @(posedge clk);
    hf_rdy <= 1'b0;
    lf_rdy <= 1'b0;
    wait_clk(3);
    bus_rd(scs_pkg::OFS_OSC_CTRL, rv);
    chk("unstable bits", 8'h00, rv & 8'h06);
  endtask

  // All eight modes: hold in crystal modes, pin use in the other five
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      do_reset(scs_pkg::scs_mode_t'(m), 1'b0, 1'b0);
      wait_clk(4);
      if (m < 3'h3) begin
        chk("crystal hold", 8'h01, {7'h0, hold});
      end else begin
        chk("pins", {6'h0, m[2] && !m[1], (m == 3'h3) || !m[0]},
          {6'h0, pins.in_pin_is_io, pins.out_pin_oe_n});
      end
      if (m == 3'h3) chk("ec hold", 8'h00, {7'h0, hold});
    end
  endtask

  // Lost external clock falls back, flag set then cleared, unmapped read
  task automatic t_fail();
    do_reset(scs_pkg::EXTERNAL_CLOCK_MODE, 1'b0, 1'b1);
    hf_rdy <= 1'b1;
    lf_rdy <= 1'b1;
    wait_clk(20);
    chk("external in use", 8'h00, {7'h0, use_int});
    bus_rd(scs_pkg::OFS_OSC_CTRL, rv);
    chk("external run bit", 8'h08, rv & 8'h08);
    @(posedge clk);
    run <= 1'b0;
    wait_clk(100);
    chk("fallback", 8'h03, {6'h0, use_int, fflag});
    bus_rd(scs_pkg::OFS_FAIL_FLAG, rv);
    chk("fail reg", 8'h04, rv & 8'h04);
    @(posedge clk);
    run <= 1'b1;
    bus_wr(scs_pkg::OFS_FAIL_FLAG, 8'h04);
    bus_rd(scs_pkg::OFS_FAIL_FLAG, rv);
    chk("fail clear", 8'h00, rv & 8'h04);
    bus_rd(2'h3, rv);
    chk("unmapped", 8'h00, rv);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_xtal();
    t_freeze();
    t_freq();
    t_modes();
    t_fail();
    end_sim();
  end

  // Watchdog, well beyond the roughly one thousand cycles the tests need
  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_sim();
  end
endmodule // tb
